/* self_refresh_control.sv */
// Self-refresh control of a DRAM device: command decode, entry, exit, internal refresh.
// Assumes command pins are synchronous to CLK_I and registers reached over APB.
`include "self_refresh_control_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Entry accepted whatever the refresh count
// - Entry decoded from pin levels at edge
// - Hold CKE low; ignore other inputs
// - Termination off inside, park restored on exit
// - DLL off on entry, reset on exit
// - Reference generator per bit, stable by exit
// - Internal refresh within min pulse, then timer
// - Abort stops refresh, no counter increment
// - On-the-fly mode samples bank-group bit 0
module self_refresh_control
    import self_refresh_control_pkg::*;
#(
    parameter int DLL_LOCK_CYC = `SRC_DLL_LOCKED_EXIT_DELAY_CYC,
    parameter int RETAIN_CYC = `SRC_RETAIN_CYC
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CS_N_I,
    input wire logic ACT_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic CKE_I,
    input wire logic BG0_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic ODT_ENABLE_O,
    output logic PARK_ASYNC_O,
    output logic DLL_ON_O,
    output logic DLL_RESET_O,
    output logic VREF_ON_O,
    output logic SELF_REFRESH_O,
    output logic INT_REFRESH_O,
    output logic [1:0] REFRESH_RATE_O
);
    import self_refresh_control_pkg::*;

    // Whole state of the controller
    typedef struct packed {
        phase_t phase;
        logic [31:0] ctrl;
        logic [2:0] rate_field;
        logic [15:0] cnt;
        logic first_ref_done;
        logic ref_active;
        logic [15:0] ref_cnt;
        logic [15:0] ref_total;
        logic [7:0] entries;
        logic [7:0] aborts;
        logic cke_d;
        logic dll_reset;
        logic [1:0] rate;
        logic [31:0] prdata;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    refresh_timer_if tif ();

    initial begin
        if (DLL_LOCK_CYC < `SRC_TXS_CYC || DLL_LOCK_CYC > 65535) begin
            $error("self_refresh_control: DLL_LOCK_CYC out of range");
        end
    end

    // Retention timer runs only inside self-refresh
    refresh_timer #(
        .PERIOD_CYC(RETAIN_CYC)
    ) u_timer (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .tif(tif)
    );

    logic entry_cmd;
    logic exit_cmd;
    logic deselect;
    logic refresh_cmd;
    logic apb_wr;
    logic apb_rd;

    assign deselect = CS_N_I;
    // Entry: chip select, RAS, CAS, CKE low with WE and ACT high
    assign entry_cmd = !CS_N_I && ACT_N_I && !RAS_N_I && !CAS_N_I && WE_N_I && !CKE_I;
    // Exit: CKE high with deselect on the bus
    assign exit_cmd = CKE_I && deselect;
    // Refresh command with CKE high
    assign refresh_cmd = !CS_N_I && ACT_N_I && !RAS_N_I && !CAS_N_I && WE_N_I && CKE_I;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I;

    // Timer requests: run inside self-refresh, kick for the early refresh
    assign tif.run = (s_r.phase == PH_SELF_REFRESH);
    assign tif.kick = (s_r.phase == PH_SELF_REFRESH) && !s_r.first_ref_done
                      && s_r.cnt == 16'(`SRC_MIN_CKE_PULSE_CYC - 1);

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.cke_d = CKE_I;
        s_nxt.dll_reset = 1'b0;
        // Internal refresh occupies a refresh cycle time
        if (s_r.ref_active) begin
            if (s_r.ref_cnt == 16'h0000) begin
                s_nxt.ref_active = 1'b0;
                s_nxt.ref_total = s_r.ref_total + 16'h0001;
            end else begin
                s_nxt.ref_cnt = s_r.ref_cnt - 16'h0001;
            end
        end
        if (tif.fire) begin
            s_nxt.ref_active = 1'b1;
            s_nxt.first_ref_done = 1'b1;
            s_nxt.ref_cnt = 16'(`SRC_REFRESH_CYCLE_TIME_NS / `SRC_CLK_PERIOD_NS - 1);
        end
        unique case (s_r.phase)
            PH_IDLE: begin
                // Accepted regardless of prior refresh count
                if (entry_cmd && s_r.cke_d) begin
                    s_nxt.phase = PH_SELF_REFRESH;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.first_ref_done = 1'b0;
                    s_nxt.entries = s_r.entries + 8'h01;
                end else if (refresh_cmd) begin
                    // On-the-fly modes pick the rate from bank-group bit 0
                    if (s_r.rate_field[2]) begin
                        s_nxt.rate = BG0_I ? s_r.rate_field[1:0] : 2'h0;
                    end else begin
                        s_nxt.rate = s_r.rate_field[1:0];
                    end
                end
            end
            PH_SELF_REFRESH: begin
                // Only CKE and chip select matter here; all other pins are ignored
                if (s_r.cnt != 16'hffff) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                end
                // Exit needs clock enable high under a deselect
                if (exit_cmd) begin
                    s_nxt.phase = PH_EXIT_NO_DLL;
                    s_nxt.dll_reset = s_r.ctrl[`SRC_CTRL_DLL_EN];
                    s_nxt.cnt = s_r.ctrl[`SRC_CTRL_ABORT_EN]
                                ? 16'(`SRC_TXS_ABORT_CYC) : 16'(`SRC_TXS_CYC);
                    // A refresh that starts on this very edge is kept: the set wins
                    if (s_r.ctrl[`SRC_CTRL_ABORT_EN] && s_r.ref_active && !tif.fire) begin
                        // Abort: drop refresh, counter untouched
                        s_nxt.ref_active = 1'b0;
                        s_nxt.aborts = s_r.aborts + 8'h01;
                    end
                end
            end
            PH_EXIT_NO_DLL: begin
                // Non-DLL window, reference must be up at its end
                if (s_r.cnt <= 16'h0001) begin
                    s_nxt.phase = PH_EXIT_DLL;
                    s_nxt.cnt = 16'(DLL_LOCK_CYC - `SRC_TXS_CYC);
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            PH_EXIT_DLL: begin
                // Re-entry allowed once non-DLL delay is over
                if (entry_cmd && s_r.cke_d) begin
                    s_nxt.phase = PH_SELF_REFRESH;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.first_ref_done = 1'b0;
                    s_nxt.entries = s_r.entries + 8'h01;
                end else if (s_r.cnt <= 16'h0001) begin
                    s_nxt.phase = PH_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
        endcase
        // APB register writes
        if (apb_wr) begin
            if (PADDR_I == `SRC_CTRL_OFF) begin
                s_nxt.ctrl = {28'h0000000, PWDATA_I[3:0]};
            end else if (PADDR_I == `SRC_MODE_OFF) begin
                s_nxt.rate_field = PWDATA_I[2:0];
            end
        end
        // Read data captured in setup phase
        if (apb_rd) begin
            unique case (PADDR_I)
                `SRC_CTRL_OFF: s_nxt.prdata = s_r.ctrl;
                `SRC_MODE_OFF: s_nxt.prdata = {29'h0000000, s_r.rate_field};
                `SRC_STAT_OFF: s_nxt.prdata = {5'h00, s_r.ref_active, s_r.rate,
                                               s_r.aborts, s_r.entries, 5'h00, s_r.phase};
                `SRC_EXTRA_OFF: s_nxt.prdata = {16'h0000, s_r.ref_total};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_r <= '0;
            s_r.ctrl <= `SRC_CTRL_RESET;
            s_r.cke_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign SELF_REFRESH_O = (s_r.phase == PH_SELF_REFRESH);
    assign ODT_ENABLE_O = (s_r.phase != PH_SELF_REFRESH);
    assign PARK_ASYNC_O = (s_r.phase == PH_EXIT_NO_DLL || s_r.phase == PH_EXIT_DLL)
                          && s_r.ctrl[`SRC_CTRL_PARK_EN];
    assign DLL_ON_O = s_r.ctrl[`SRC_CTRL_DLL_EN] && (s_r.phase != PH_SELF_REFRESH);
    assign DLL_RESET_O = s_r.dll_reset;
    assign VREF_ON_O = !(SELF_REFRESH_O && s_r.ctrl[`SRC_CTRL_VREF_OFF]);
    assign INT_REFRESH_O = s_r.ref_active;
    assign REFRESH_RATE_O = s_r.rate;
    assign PRDATA_O = s_r.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = 1'b0;
endmodule : self_refresh_control
`default_nettype wire

/* self_refresh_control_regs.svh */
// Constants for the self-refresh control block: offsets, fields, reset values, timing.
// Assumes a 200 MHz core clock and an APB slave with 32-bit data.
`ifndef SELF_REFRESH_CONTROL_REGS_SVH
`define SELF_REFRESH_CONTROL_REGS_SVH

// Register byte offsets
`define SRC_CTRL_OFF 12'h000
`define SRC_MODE_OFF 12'h004
`define SRC_STAT_OFF 12'h008
`define SRC_EXTRA_OFF 12'h00c

// Control register fields
`define SRC_CTRL_DLL_EN 0
`define SRC_CTRL_PARK_EN 1
`define SRC_CTRL_VREF_OFF 2
`define SRC_CTRL_ABORT_EN 3
`define SRC_CTRL_RESET 32'h0000_0001

// Mode register field: refresh-rate field in bits 2:0
`define SRC_MODE_RESET 32'h0000_0000

// Timing figures in ns and cycles at 5 ns
`define SRC_CLK_PERIOD_NS 5
`define SRC_REFRESH_CYCLE_TIME_NS 260
`define SRC_TXS_EXTRA_NS 10
`define SRC_TXS_NS (`SRC_REFRESH_CYCLE_TIME_NS + `SRC_TXS_EXTRA_NS)
`define SRC_TXS_CYC ((`SRC_TXS_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_MIN_CKE_PULSE_NS 5
`define SRC_MIN_CKE_PULSE_CYC ((`SRC_MIN_CKE_PULSE_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_DLL_LOCKED_EXIT_DELAY_CYC 768
`define SRC_TXS_ABORT_NS 170
`define SRC_TXS_ABORT_CYC ((`SRC_TXS_ABORT_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_RETAIN_NS 7800
`define SRC_RETAIN_CYC (`SRC_RETAIN_NS / `SRC_CLK_PERIOD_NS)

`endif

/* self_refresh_control_pkg.sv */
// Types shared by the self-refresh control block.
// Assumes the constants header is compiled alongside.
package self_refresh_control_pkg;
    // Operating phase of the device
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SELF_REFRESH,
        PH_EXIT_NO_DLL,
        PH_EXIT_DLL
    } phase_t;

    // Refresh-rate field encodings
    typedef enum logic [2:0] {
        RATE_FIXED_1X = 3'h0,
        RATE_FIXED_2X = 3'h1,
        RATE_FIXED_4X = 3'h2,
        RATE_OTF_2X = 3'h5,
        RATE_OTF_4X = 3'h6
    } refresh_rate_t;
endpackage : self_refresh_control_pkg

/* refresh_timer_if.sv */
// Interface joining the controller to its internal refresh timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface refresh_timer_if;
    logic run; // Timer allowed to fire
    logic kick; // Force an immediate internal refresh
    logic fire; // One-cycle internal refresh request
    modport ctrl (output run, output kick, input fire);
    modport timer (input run, input kick, output fire);
endinterface : refresh_timer_if
`default_nettype wire

/* refresh_timer.sv */
// Internal self-refresh retention timer.
// Assumes a 200 MHz clock; the period parameter may be shortened in simulation.
`include "self_refresh_control_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module refresh_timer #(
    parameter int PERIOD_CYC = `SRC_RETAIN_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    refresh_timer_if.timer tif
);
    // Whole state of the timer
    typedef struct packed {
        logic [15:0] cnt;
        logic fire;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    initial begin
        if (PERIOD_CYC < 2 || PERIOD_CYC > 65535) begin
            $error("refresh_timer: PERIOD_CYC out of range");
        end
    end

    assign tif.fire = s_r.fire;

    // Count down while running; a kick fires at once
    always_comb begin
        s_nxt = s_r;
        s_nxt.fire = 1'b0;
        if (!tif.run) begin
            s_nxt.cnt = 16'(PERIOD_CYC - 1);
        end else if (tif.kick || s_r.cnt == 16'h0000) begin
            s_nxt.fire = 1'b1;
            s_nxt.cnt = 16'(PERIOD_CYC - 1);
        end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : refresh_timer
`default_nettype wire

/* self_refresh_control_asserts.sv */
// Port-level timing checks for the self-refresh control block.
// Assumes it is bound to self_refresh_control and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module self_refresh_control_chk (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CS_N_I,
    input wire logic ACT_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic CKE_I,
    input wire logic ODT_ENABLE_O,
    input wire logic PARK_ASYNC_O,
    input wire logic DLL_ON_O,
    input wire logic DLL_RESET_O,
    input wire logic SELF_REFRESH_O,
    input wire logic INT_REFRESH_O
);
    logic [9:0] gap_r; // Cycles since self-refresh ended, saturating
    // Entry is refused in the non-DLL exit window, so the checker tracks it
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gap_r <= 10'h3ff;
        end else if (SELF_REFRESH_O) begin
            gap_r <= 10'h000;
        end else if (gap_r != 10'h3ff) begin
            gap_r <= gap_r + 10'h001;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    entry_taken_a: assert property (!CS_N_I && ACT_N_I && !RAS_N_I && !CAS_N_I && WE_N_I
        && !CKE_I && $past(CKE_I) && !SELF_REFRESH_O && gap_r >= 10'h03c |=> SELF_REFRESH_O)
        else $error("entry command not taken");
    stay_in_a: assert property (SELF_REFRESH_O && !CKE_I |=> SELF_REFRESH_O)
        else $error("self-refresh left with clock enable low");
    exit_taken_a: assert property (SELF_REFRESH_O && CKE_I && CS_N_I |=> !SELF_REFRESH_O)
        else $error("exit not taken");
    odt_off_a: assert property (SELF_REFRESH_O |-> !ODT_ENABLE_O)
        else $error("termination on in self-refresh");
    odt_back_a: assert property ($fell(SELF_REFRESH_O) |-> ODT_ENABLE_O)
        else $error("termination not restored");
    dll_off_a: assert property (SELF_REFRESH_O |-> !DLL_ON_O)
        else $error("DLL running in self-refresh");
    dll_reset_a: assert property ($fell(SELF_REFRESH_O) |-> ##[0:1] DLL_RESET_O)
        else $error("no DLL reset on exit");
    dll_pulse_a: assert property (DLL_RESET_O |-> gap_r <= 10'h001 ##1 !DLL_RESET_O)
        else $error("DLL reset pulse misplaced");
    int_kick_a: assert property ($rose(SELF_REFRESH_O) |-> ##[0:8] INT_REFRESH_O)
        else $error("no internal refresh after entry");
    park_exit_a: assert property (PARK_ASYNC_O |-> !SELF_REFRESH_O)
        else $error("park termination in self-refresh");
    cover property ($rose(SELF_REFRESH_O));
    cover property ($fell(SELF_REFRESH_O));
    cover property (SELF_REFRESH_O && INT_REFRESH_O && CKE_I);
endmodule : self_refresh_control_chk
bind self_refresh_control self_refresh_control_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .CS_N_I(CS_N_I), .ACT_N_I(ACT_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I),
    .CKE_I(CKE_I), .ODT_ENABLE_O(ODT_ENABLE_O), .PARK_ASYNC_O(PARK_ASYNC_O),
    .DLL_ON_O(DLL_ON_O), .DLL_RESET_O(DLL_RESET_O), .SELF_REFRESH_O(SELF_REFRESH_O),
    .INT_REFRESH_O(INT_REFRESH_O));
`default_nettype wire

/* dram_host_model.sv */
// Behavioural memory controller driving command pins and clock enable.
// Assumes the device samples the pins on the rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module dram_host_model (
    input wire logic clk_i,
    output logic cs_n_o,
    output logic [3:0] cmd_n_o, // ACT, RAS, CAS, WE in that order
    output logic cke_o,
    output logic bg0_o
);
    logic sel_r = 1'b0; // A command slot is selected
    logic [3:0] junk_r = 4'h5; // Idle pins toggle so no stale value looks valid
    assign cs_n_o = ~sel_r; // Deselect on every edge without a command
    assign cmd_n_o = sel_r ? 4'b1001 : junk_r; // Refresh and entry share a pattern
    initial begin
        cke_o = 1'b1;
        bg0_o = 1'b0;
    end
    // Free-running pattern on unselected lines
    always @(posedge clk_i) begin
        junk_r <= ~junk_r;
    end
    // One command edge, then deselect; callers start from idle
    task automatic issue(input logic cke, input logic bg);
        @(posedge clk_i);
        sel_r <= 1'b1;
        cke_o <= cke; // Low keeps the device in self-refresh
        bg0_o <= bg;
        @(posedge clk_i);
        sel_r <= 1'b0;
        bg0_o <= ~bg;
    endtask : issue
    // Exit: clock enable rises under deselect
    task automatic leave();
        @(posedge clk_i);
        cke_o <= 1'b1;
    endtask : leave
endmodule : dram_host_model
`default_nettype wire

/* self_refresh_control_tb.sv */
// Self-checking bench for the self-refresh control block.
// Assumes the controller model and the checker are compiled before it.
`include "self_refresh_control_regs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module self_refresh_control_tb;
    import self_refresh_control_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, odt_en, park, dll_on, dll_rst, vref_on, in_sr, int_ref;
    logic [1:0] rate;
    logic cs_n, cke, bg0;
    logic [3:0] cmd_n;
    int miscompares = 0;
    int check_count = 0;
    // Rate modes and the rate expected with bank-group bit high, then low
    logic [2:0] mode_tab [5] = '{RATE_FIXED_1X, RATE_FIXED_2X, RATE_FIXED_4X, RATE_OTF_2X,
        RATE_OTF_4X};
    logic [1:0] exp1 [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
    logic [1:0] exp0 [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
    // Short DLL window keeps the run brief
    self_refresh_control #(.DLL_LOCK_CYC(80), .RETAIN_CYC(16)) u_dut (.CLK_I(clk),
        .RESET_N_I(rst_n), .CS_N_I(cs_n), .ACT_N_I(cmd_n[3]), .RAS_N_I(cmd_n[2]),
        .CAS_N_I(cmd_n[1]), .WE_N_I(cmd_n[0]), .CKE_I(cke), .BG0_I(bg0), .PADDR_I(paddr),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ODT_ENABLE_O(odt_en),
        .PARK_ASYNC_O(park), .DLL_ON_O(dll_on), .DLL_RESET_O(dll_rst), .VREF_ON_O(vref_on),
        .SELF_REFRESH_O(in_sr), .INT_REFRESH_O(int_ref), .REFRESH_RATE_O(rate));
    dram_host_model u_host (.clk_i(clk), .cs_n_o(cs_n), .cmd_n_o(cmd_n), .cke_o(cke),
        .bg0_o(bg0));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One APB transfer; waits for ready, data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        `CHK("apb error", 1'b0, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic close_out();
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // Whole run takes about 310 cycles
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
    initial begin
        logic [31:0] q, n;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `SRC_CTRL_OFF, 32'h0, q);
        `CHK("ctrl reset", `SRC_CTRL_RESET, q)
        apb(1'b0, `SRC_MODE_OFF, 32'h0, q);
        `CHK("mode reset", `SRC_MODE_RESET, q)
        apb(1'b1, 12'h010, 32'hffff_ffff, q);
        apb(1'b0, 12'h010, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 5; i++) begin // Temperature refresh off; no entry from 4x
            apb(1'b1, `SRC_MODE_OFF, {29'h0, mode_tab[i]}, q);
            u_host.issue(1'b1, 1'b1);
            cyc(2);
            `CHK("rate bg high", exp1[i], rate)
            u_host.issue(1'b1, 1'b0);
            cyc(2);
            `CHK("rate bg low", exp0[i], rate)
        end
        apb(1'b1, `SRC_CTRL_OFF, 32'h3, q);
        apb(1'b1, `SRC_MODE_OFF, {29'h0, RATE_OTF_2X}, q);
        repeat (3) u_host.issue(1'b1, 1'b1); // Odd count of double-rate refreshes
        u_host.issue(1'b0, 1'b0);
        cyc(2);
        `CHK("entry", 1'b1, in_sr)
        `CHK("odt off", 1'b0, odt_en)
        `CHK("dll off", 1'b0, dll_on)
        `CHK("vref kept", 1'b1, vref_on)
        u_host.issue(1'b0, 1'b0);
        cyc(25); // Stays in past the minimum residency, clock never halted
        `CHK("pins ignored", 1'b1, in_sr)
        `CHK("rate held", 2'h1, rate)
        u_host.leave();
        cyc(1);
        `CHK("dll reset", 1'b1, dll_rst)
        cyc(1);
        `CHK("exit", 1'b0, in_sr)
        `CHK("odt on", 1'b1, odt_en)
        `CHK("park on", 1'b1, park)
        // Control write and extra-register read go out in the DLL exit window
        cyc(60); // Deselect only through the non-DLL exit delay
        repeat (2) u_host.issue(1'b1, 1'b1); // Extra refreshes before re-entry
        apb(1'b1, `SRC_CTRL_OFF, 32'hf, q);
        apb(1'b0, `SRC_EXTRA_OFF, 32'h0, n);
        u_host.issue(1'b0, 1'b0);
        cyc(1);
        for (int k = 0; k < 10 && int_ref !== 1'b1; k++) cyc(1);
        `CHK("int refresh", 1'b1, int_ref)
        `CHK("vref off", 1'b0, vref_on)
        u_host.leave();
        cyc(3);
        `CHK("abort", 1'b0, int_ref)
        apb(1'b0, `SRC_EXTRA_OFF, 32'h0, q);
        `CHK("no count", n, q)
        apb(1'b0, `SRC_STAT_OFF, 32'h0, q);
        `CHK("aborts", 8'h01, q[23:16])
        cyc(90);
        `CHK("park off", 1'b0, park)
        `CHK("dll on", 1'b1, dll_on)
        `CHK("vref on", 1'b1, vref_on)
        close_out();
    end
endmodule : self_refresh_control_tb
`default_nettype wire
